/* design/dbs_sram_port.sv */
`timescale 1ns/1ps
`include "dbs_regs.svh"

// Synchronous FIFO, single clock
module dbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0] cnt_q;
  logic push, pop;

  // Honest flags from the occupancy count
  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap at depth
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // dbs_fifo

// Burst SRAM access port, device side
module dbs_sram_port import dbs_pkg::*; (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link clock: rise is the true clock, fall the complementary rise
  input wire logic link_clk,
  // Command pins
  input wire logic load_strobe_n,
  input wire logic rw_select,
  input wire dbs_addr_t addr,
  input wire dbs_sel_t byte_write_select_n,
  input wire logic pll_off_select_n,
  // Data pins
  input wire dbs_word_t dq_i,
  output dbs_word_t dq_o,
  output logic dq_oe,
  output logic read_valid_flag,
  // Status
  output logic pll_lock_flag,
  output logic wr_buf_ready
);
  localparam int CLK_NS = `DBS_CLK_NS;
  // Least times round up to whole cycles
  localparam int LOCK_CYC = (`DBS_LOCK_US * `DBS_NS_PER_US + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (`DBS_PLL_RST_NS + CLK_NS - 1) / CLK_NS;
  // Activity is only seen once per link period, so the quiet window adds it
  localparam int QUIET_CYC = RST_CYC + `DBS_LINK_NS / CLK_NS;
  localparam int WRW = $bits(dbs_wr_s);

  dbs_word_t mem_q [2**`DBS_AW];
  logic lrst_s1_q, link_rst_q, poff_s1_q, pll_on_q;
  logic rd1_v_q, wr1_v_q, wr2_v_q, f_v_q, oe_p_q, oe_n_q, rv_q, act_q;
  dbs_addr_t cmd_a_q, wr2_a_q;
  dbs_word_t f0_q, f1_q, q0_q, q1_pre_q, q1_q, w0_q, w1_q;
  dbs_sel_t s0_q, s1_q;
  logic rd_go, wr_go, out_v, drain_ready, drain_valid;
  dbs_wr_s push_e, drain_e;
  dbs_word_t rd_w0, rd_w1, old0, old1, new0, new1;
  dbs_addr_t drain_a1;

  // Second word of a burst: address bit 0 flips, pair never crossed
  function automatic dbs_addr_t dbs_next(dbs_addr_t a);
    return {a[`DBS_AW-1:1], a[0] ^ 1'h1};
  endfunction

  // Reset and PLL select brought into the link domain
  always_ff @(posedge link_clk) begin
    lrst_s1_q <= sys_rst;
    link_rst_q <= lrst_s1_q;
    poff_s1_q <= pll_off_select_n;
    pll_on_q <= poff_s1_q;
  end

  // Command decode; load strobe high starts nothing
  assign rd_go = !load_strobe_n && rw_select;
  assign wr_go = !load_strobe_n && !rw_select;

  // Command capture on the true rise
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      rd1_v_q <= 1'h0;
      wr1_v_q <= 1'h0;
    end else begin
      rd1_v_q <= rd_go;
      wr1_v_q <= wr_go;
    end
    if (!load_strobe_n) begin
      cmd_a_q <= addr;
    end
  end

  // Array read ports for the pending read
  assign rd_w0 = mem_q[cmd_a_q];
  assign rd_w1 = mem_q[dbs_next(cmd_a_q)];

  // Extra fetch stage only with the PLL on
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      f_v_q <= 1'h0;
    end else begin
      f_v_q <= rd1_v_q && pll_on_q;
    end
    if (rd1_v_q) begin
      f0_q <= rd_w0;
      f1_q <= rd_w1;
    end
  end

  // Latency select: two cycles with PLL, one without
  assign out_v = pll_on_q ? f_v_q : rd1_v_q;

  // True-rise output stage; words hold when idle
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      oe_p_q <= 1'h0;
    end else begin
      oe_p_q <= out_v;
    end
    if (out_v) begin
      q0_q <= pll_on_q ? f0_q : rd_w0;
      q1_pre_q <= pll_on_q ? f1_q : rd_w1;
    end
  end

  // Complementary-rise stage: second word and valid flag
  always_ff @(negedge link_clk) begin
    if (link_rst_q) begin
      oe_n_q <= 1'h0;
      rv_q <= 1'h0;
    end else begin
      oe_n_q <= oe_p_q;
      rv_q <= out_v;
    end
    if (oe_p_q) begin
      q1_q <= q1_pre_q;
    end
  end

  // Clock level steers the DDR mux; a stopped clock freezes the pins
  assign dq_o = link_clk ? q0_q : q1_q;
  assign dq_oe = link_clk ? oe_p_q : oe_n_q;
  assign read_valid_flag = rv_q;

  // Write beat 0 on the true rise after the command
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      wr2_v_q <= 1'h0;
    end else begin
      wr2_v_q <= wr1_v_q;
    end
    if (wr1_v_q) begin
      w0_q <= dq_i;
      s0_q <= byte_write_select_n;
      wr2_a_q <= cmd_a_q;
    end
  end

  // Write beat 1 on the complementary rise of the same cycle
  always_ff @(negedge link_clk) begin
    if (wr2_v_q) begin
      w1_q <= dq_i;
      s1_q <= byte_write_select_n;
    end
  end

  // Posted writes queue here; reads have the array first
  assign push_e = '{addr: wr2_a_q, d0: w0_q, s0_n: s0_q, d1: w1_q, s1_n: s1_q};
  assign drain_ready = !rd1_v_q;

  dbs_fifo #(
    .WIDTH(WRW),
    .DEPTH(`DBS_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(link_clk),
    .rst(link_rst_q),
    .in_valid(wr2_v_q),
    .in_ready(wr_buf_ready),
    .in_data(push_e),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_e)
  );

  assign drain_a1 = dbs_next(drain_e.addr);
  assign old0 = mem_q[drain_e.addr];
  assign old1 = mem_q[drain_a1];

  // Lane merge: a high select keeps the stored lane
  for (genvar l = 0; l < `DBS_LANES; l++) begin : g_lane
    assign new0[l*`DBS_LW +: `DBS_LW] = drain_e.s0_n[l] ?
      old0[l*`DBS_LW +: `DBS_LW] : drain_e.d0[l*`DBS_LW +: `DBS_LW];
    assign new1[l*`DBS_LW +: `DBS_LW] = drain_e.s1_n[l] ?
      old1[l*`DBS_LW +: `DBS_LW] : drain_e.d1[l*`DBS_LW +: `DBS_LW];
  end

  // Array commit, one burst per true rise
  always_ff @(posedge link_clk) begin
    if (drain_valid && drain_ready) begin
      mem_q[drain_e.addr] <= new0;
      mem_q[drain_a1] <= new1;
    end
  end

  // Activity marker for the lock timer
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      act_q <= 1'h0;
    end else begin
      act_q <= !act_q;
    end
  end

  logic act_s1_q, act_s2_q, act_s3_q, po_s1_q, po_s2_q;
  logic [$clog2(QUIET_CYC+1)-1:0] quiet_q;
  logic [$clog2(LOCK_CYC+1)-1:0] lock_q;
  logic stopped;

  // Link activity and PLL select into the system domain
  always_ff @(posedge clk) begin
    act_s1_q <= act_q;
    act_s2_q <= act_s1_q;
    act_s3_q <= act_s2_q;
    po_s1_q <= pll_off_select_n;
    po_s2_q <= po_s1_q;
  end

  // Quiet counter: clock stalled long enough resets the PLL
  always_ff @(posedge clk) begin
    if (sys_rst || (act_s2_q ^ act_s3_q)) begin
      quiet_q <= '0;
    end else if (!stopped) begin
      quiet_q <= quiet_q + 1'b1;
    end
  end
  assign stopped = (quiet_q >= ($bits(quiet_q))'(QUIET_CYC));

  // Lock timer runs only with the PLL on and the clock alive
  always_ff @(posedge clk) begin
    if (sys_rst || stopped || !po_s2_q) begin
      lock_q <= '0;
      pll_lock_flag <= 1'h0;
    end else begin
      if (lock_q != ($bits(lock_q))'(LOCK_CYC)) begin
        lock_q <= lock_q + 1'b1;
      end
      pll_lock_flag <= (lock_q == ($bits(lock_q))'(LOCK_CYC));
    end
  end

  // Checks; a flop loaded at one rise is only seen at the next sample
  a_rd_lat_pll: assert property (@(posedge link_clk) disable iff (link_rst_q)
    rd_go && pll_on_q && $stable(pll_on_q) |-> ##3 oe_p_q)
    else $error("PLL read not driven two cycles later");
  a_rd_lat_off: assert property (@(posedge link_clk) disable iff (link_rst_q)
    rd_go && !pll_on_q && $stable(pll_on_q) |-> ##1 !f_v_q ##1 oe_p_q)
    else $error("Legacy read not driven one cycle later");
  a_valid_lead: assert property (@(posedge link_clk) disable iff (link_rst_q)
    $rose(oe_p_q) |-> $past(rv_q) && !$past(rv_q, 2))
    else $error("Valid flag did not lead the first word");
  a_valid_timing: assert property (@(negedge link_clk) disable iff (link_rst_q)
    rv_q |-> ##1 oe_n_q)
    else $error("Valid flag out of step with data pins");
  a_wr_beats: assert property (@(posedge link_clk) disable iff (link_rst_q)
    wr_go |-> ##1 wr1_v_q ##1 wr2_v_q)
    else $error("Write beats not captured at t+1");
  a_mask_hold: assert property (@(posedge link_clk) disable iff (link_rst_q)
    drain_valid && drain_ready && (&drain_e.s0_n) |-> new0 == old0)
    else $error("Deselected beat altered memory");
  a_reset_float: assert property (@(posedge link_clk)
    $past(link_rst_q) |-> !oe_p_q && !rv_q)
    else $error("Data pins driven after reset");
  a_nop_float: assert property (@(posedge link_clk) disable iff (link_rst_q)
    !rd_go [*3] |-> ##1 !oe_p_q)
    else $error("Bus still driven after idle cycles");
endmodule // dbs_sram_port

/* shared/dbs_pkg.sv */
`include "dbs_regs.svh"
package dbs_pkg;
  typedef logic [`DBS_DW-1:0] dbs_word_t;
  typedef logic [`DBS_AW-1:0] dbs_addr_t;
  typedef logic [`DBS_LANES-1:0] dbs_sel_t;
  // One posted write burst: address, two beats, two select sets
  typedef struct packed {
    dbs_addr_t addr;
    dbs_word_t d0;
    dbs_sel_t s0_n;
    dbs_word_t d1;
    dbs_sel_t s1_n;
  } dbs_wr_s;
endpackage

/* shared/dbs_regs.svh */
// Summary of operation
// - Read-valid flag rises half a cycle before the first read word.
// - Read-valid flag is launched like a data pin, aligned to the clocks.
// - PLL locks 20 us after a stable clock; no PLL timing before.
// - Clocks slowed or stopped for 30 ns reset the PLL; optional. Here a stop resets it after 5 system cycles (200 ns).
// - PLL-off select low bypasses the PLL; read latency becomes one cycle.
// - Write: load low, select low at t; data beats at t+1 rise and fall.
// - Read: load low, select high at t; words driven at t+2 rise and fall.
// - First word uses latched address, second the next address inside the burst.
// - Write data captured, read data driven, on both clock edges.
// - Select 0 gates lane 8:0, select 1 lane 17:9; others keep contents.
// - All selects high on a beat leave memory unchanged for that beat.
// - Single-select build: low select writes bits 8:0, high writes nothing.
// - Selects are sampled separately with each beat of one write.
// - After reset the port is deselected with data pins high impedance.
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH
// Data word, lanes and array depth
`define DBS_DW 18
`define DBS_LANES 2
`define DBS_LW 9
`define DBS_AW 9
`define DBS_FIFO_DEPTH 32
// Timing, in the units printed
`define DBS_CLK_NS 40
`define DBS_LOCK_US 20
`define DBS_PLL_RST_NS 30
`define DBS_LINK_NS 160
`define DBS_NS_PER_US 1000
`endif

/* verification/dbs_ctl_model.sv */
`timescale 1ns/1ps

// Memory controller stand-in: link clock, commands and write beats
module dbs_ctl_model import dbs_pkg::*; (
  // Link outputs
  output logic link_clk,
  output logic load_strobe_n,
  output logic rw_select,
  output dbs_addr_t addr,
  output dbs_sel_t byte_write_select_n,
  output dbs_word_t dq_i,
  // Device answers and the PLL-off select
  input wire dbs_word_t dq_o,
  input wire logic dq_oe,
  input wire logic read_valid_flag,
  input wire logic pll_off_select_n
);
  logic run;

  // Free clock; when stopped it parks high for a quick restart
  initial begin
    link_clk = 1'b0;
    run = 1'b1;
    load_strobe_n = 1'b1;
    rw_select = 1'b0;
    addr = '0;
    byte_write_select_n = 2'b11;
    dq_i = '0;
    #13;
    forever begin
      #80;
      if (run || !link_clk) link_clk = ~link_clk;
    end
  end

  // One command rise, then load high and an address that no longer holds its old value
  task automatic cmd(input logic rd, input dbs_addr_t a);
    @(posedge link_clk) #1;
    load_strobe_n = 1'b0;
    rw_select = rd;
    addr = a;
    @(posedge link_clk) #1;
    load_strobe_n = 1'b1;
    addr = ~a;
  endtask

  task automatic nop(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // Spacing before every write keeps clear of a prior read
  task automatic wr(input dbs_addr_t a, input dbs_word_t d0, input dbs_sel_t s0,
                    input dbs_word_t d1, input dbs_sel_t s1);
    nop(1);
    cmd(1'b0, a);
    dq_i = d0;
    byte_write_select_n = s0;
    @(posedge link_clk) #1;
    dq_i = d1;
    byte_write_select_n = s1;
    @(negedge link_clk) #1;
    dq_i = ~d1;
    byte_write_select_n = 2'b11;
  endtask

  // Flags: valid before, valid at data, enable at data, enable after
  task automatic rd(input dbs_addr_t a, output dbs_word_t w0, output dbs_word_t w1,
                    output logic [3:0] f);
    int lat;
    lat = pll_off_select_n ? 2 : 1;
    cmd(1'b1, a);
    repeat (lat - 1) @(posedge link_clk);
    #1;
    f[0] = read_valid_flag;
    @(posedge link_clk) #1;
    f[1] = read_valid_flag;
    f[2] = dq_oe;
    w0 = dq_o;
    @(negedge link_clk) #1;
    w1 = dq_o;
    @(posedge link_clk) #1;
    f[3] = dq_oe;
  endtask
endmodule // dbs_ctl_model

/* verification/dbs_sram_port_tb.sv */
`timescale 1ns/1ps

module dbs_sram_port_tb import dbs_pkg::*;;
  logic clk, sys_rst, link_clk, load_strobe_n, rw_select, pll_off_select_n;
  logic dq_oe, read_valid_flag, pll_lock_flag, wr_buf_ready;
  dbs_addr_t addr;
  dbs_sel_t byte_write_select_n;
  dbs_word_t dq_i, dq_o, w0, w1;
  logic [3:0] f;
  int n_errors = 0;
  int n_compared = 0;

  dbs_ctl_model ctl (.link_clk(link_clk), .load_strobe_n(load_strobe_n),
    .rw_select(rw_select), .addr(addr), .byte_write_select_n(byte_write_select_n),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .read_valid_flag(read_valid_flag),
    .pll_off_select_n(pll_off_select_n));
  dbs_sram_port dut (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .load_strobe_n(load_strobe_n), .rw_select(rw_select), .addr(addr),
    .byte_write_select_n(byte_write_select_n), .pll_off_select_n(pll_off_select_n),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .read_valid_flag(read_valid_flag),
    .pll_lock_flag(pll_lock_flag), .wr_buf_ready(wr_buf_ready));

  // 25 MHz system clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Lock must come near the fixed count, never long before
  task automatic t_lock();
    int n;
    n = 0;
    while (pll_lock_flag !== 1'b1 && n < 700) begin
      @(negedge clk);
      n++;
    end
    chk("lock time", 18'h1, 18'((n >= 480) && (n <= 520)));
    $display("test lock done");
  endtask

  task automatic t_burst();
    ctl.wr(9'h010, 18'h12345, 2'b00, 18'h2abcd, 2'b00);
    ctl.nop(4);
    ctl.rd(9'h010, w0, w1, f);
    chk("word0", 18'h12345, w0);
    chk("word1", 18'h2abcd, w1);
    chk("read flags", 18'h6, {14'h0, f});
    ctl.rd(9'h011, w0, w1, f);
    chk("odd word0", 18'h2abcd, w0);
    chk("odd word1", 18'h12345, w1);
    $display("test burst done");
  endtask

  // Lane 0 only on beat 0, lane 1 only on beat 1, then a fully masked write
  task automatic t_lanes();
    ctl.wr(9'h010, 18'h0, 2'b10, 18'h0, 2'b01);
    ctl.wr(9'h010, 18'h3ffff, 2'b11, 18'h3ffff, 2'b11);
    ctl.nop(4);
    ctl.rd(9'h010, w0, w1, f);
    chk("lane0 word0", {9'h091, 9'h000}, w0);
    chk("lane1 word1", {9'h000, 9'h1cd}, w1);
    $display("test lanes done");
  endtask

  // Stopped clock drops lock but keeps pins and contents
  task automatic t_stop();
    ctl.run = 1'b0;
    repeat (20) @(negedge clk);
    chk("lock stopped", 18'h0, 18'(pll_lock_flag));
    chk("oe stopped", 18'h0, 18'(dq_oe));
    ctl.run = 1'b1;
    t_lock();
    ctl.rd(9'h010, w0, w1, f);
    chk("kept word0", 18'h12200, w0);
    $display("test stop done");
  endtask

  task automatic t_legacy();
    @(negedge clk);
    pll_off_select_n = 1'b0;
    ctl.nop(4);
    chk("lock off", 18'h0, 18'(pll_lock_flag));
    ctl.rd(9'h011, w0, w1, f);
    chk("legacy word0", 18'h001cd, w0);
    chk("legacy flags", 18'h6, {14'h0, f});
    $display("test legacy done");
  endtask

  // Long enough for two lock waits and all traffic
  initial begin
    #200000;
    n_errors++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    pll_off_select_n = 1'b1;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    chk("oe idle", 18'h0, 18'(dq_oe));
    chk("buf ready", 18'h1, 18'(wr_buf_ready));
    t_lock();
    t_burst();
    t_lanes();
    t_stop();
    t_legacy();
    results();
  end
endmodule // dbs_sram_port_tb
